// ---- rtl/hsmap_defs.svh ----
// Constants of the host serial memory access port
//
// Behaviour
// R1 - Sample input on rising serial clock, change output on falling; modes 0 and 3.
// R2 - Bytes are eight bits, most significant first, one per eight rising edges.
// R3 - Host keeps select low and clocks whole bytes for multi-byte transfers.
// R4 - Select rising ends the transfer and returns to command reception.
// R5 - A partial byte at select rising is discarded without action.
// R6 - Serial input is ignored while read data is shifted out.
// R7 - Each frame opens with a command byte; the byte returned meanwhile is dummy.
// R8 - Fast commands 0,W,index,0,0 reach registers 0x8000 to 0x800F.
// R9 - Further fast bytes access ascending registers from the addressed one.
// R10 - Writes to reserved register locations are ignored.
// R11 - Low 32K addresses are RAM, upper 128 registers; identical serial timing.
// R12 - Before ready, writes are blocked and reads return master status.
// R13 - 16-bit pointer: 0x8C loads it high byte first, 0x88 returns it.
// R14 - 0x80 reads, 0x84 writes at pointer; pointer increments after each byte.
// R15 - Host sends one command per frame; pointer commands end their frame.
// R16 - Increment stops at 0x7FFF in RAM and 0xFFFF in registers.
// R17 - Host serial clock stays at or below 20 MHz.
// R18 - Serial output is driven only while select is low.
`ifndef HSMAP_DEFS_SVH
`define HSMAP_DEFS_SVH

// ----------------------------------------------------------------
// Command bytes
// ----------------------------------------------------------------
`define HSMAP_CMD_MEM_RD   8'h80
`define HSMAP_CMD_MEM_WR   8'h84
`define HSMAP_CMD_PTR_RD   8'h88
`define HSMAP_CMD_PTR_WR   8'h8c

// ----------------------------------------------------------------
// Address space
// ----------------------------------------------------------------
`define HSMAP_FAST_BASE    12'h800
`define HSMAP_RAM_TOP      16'h7fff
`define HSMAP_REG_TOP      16'hffff
`define HSMAP_RSV_MASK     16'h0a00
`define HSMAP_BYTE_LAST    3'h7

`endif

// ---- rtl/hsmap_pkg.sv ----
// Types of the host serial memory access port
package hsmap_pkg;
  // Frame phases: the command byte and the phases it selects
  typedef enum logic [2:0] {
    ST_CMD,
    ST_RD,
    ST_WR,
    ST_PTR_RD,
    ST_PTR_WR,
    ST_SKIP
  } hsmap_state_t;
endpackage

// ---- rtl/hsmap_top.sv ----
// Host serial slave port reaching RAM and registers through a pointer
`timescale 1ns/1ps
`default_nettype none
`include "hsmap_defs.svh"

module hsmap_top
  import hsmap_pkg::*;
#(
  parameter logic [15:0] RSV_MASK = `HSMAP_RSV_MASK
) (
  input  wire  logic        CLK,
  input  wire  logic        RST_N,
  input  wire  logic        SCK,
  input  wire  logic        CS_N,
  input  wire  logic        SI,
  output var   logic        SO,
  output var   logic        SO_OE,
  input  wire  logic        HOST_READY,
  input  wire  logic [7:0]  STATUS_BYTE,
  output var   logic [15:0] MEM_RD_ADDR,
  input  wire  logic [7:0]  MEM_RD_DATA,
  output var   logic        MEM_WR_VALID,
  input  wire  logic        MEM_WR_READY,
  output var   logic [15:0] MEM_WR_ADDR,
  output var   logic [7:0]  MEM_WR_DATA
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0]   sck_q;
  logic [1:0]   cs_q;
  logic [1:0]   si_q;
  hsmap_state_t state_q;
  logic [2:0]   bit_q;
  logic [1:0]   bidx_q;
  logic [6:0]   rx_q;
  logic [6:0]   tx_q;
  logic         so_q;
  logic         oe_q;
  logic [15:0]  map_q;
  logic [15:0]  fast_q;
  logic         use_fast_q;
  logic [15:0]  rda_q;
  logic         pend_q;
  logic [23:0]  pend_w_q;
  logic         v0_q;
  logic         v1_q;
  logic [23:0]  b0_q;
  logic [23:0]  b1_q;

  // Third sck stage feeds the edge detector, never the first one
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      sck_q <= 3'h0;
      cs_q  <= 2'h3;
      si_q  <= 2'h0;
    end else begin
      sck_q <= {sck_q[1:0], SCK};
      cs_q  <= {cs_q[0], CS_N};
      si_q  <= {si_q[0], SI};
    end
  end

  // ----------------------------------------------------------------
  // Edge and byte decode
  // ----------------------------------------------------------------
  // Only edges matter, so an idle-high or idle-low clock both work
  wire       cs_hi     = cs_q[1];
  wire       rise      = sck_q[1] & ~sck_q[2] & ~cs_hi;  // R1
  wire       fall      = ~sck_q[1] & sck_q[2] & ~cs_hi;  // R1
  wire       byte_done = rise & (bit_q == `HSMAP_BYTE_LAST);  // R2
  wire [7:0] rx_byte   = {rx_q, si_q[1]};  // R2
  wire       rd_state  = (state_q == ST_RD) | (state_q == ST_PTR_RD);
  wire [15:0] cur_addr = use_fast_q ? fast_q : map_q;
  wire       is_fast   = ~rx_byte[7] & (rx_byte[1:0] == 2'h0);  // R8
  wire       at_top    = (cur_addr == `HSMAP_RAM_TOP) | (cur_addr == `HSMAP_REG_TOP);
  wire [15:0] nxt_addr = at_top ? cur_addr : cur_addr + 16'h0001;  // R16
  wire       rsv_hit   = (cur_addr[15:4] == `HSMAP_FAST_BASE) & RSV_MASK[cur_addr[3:0]];
  wire       wr_take   = byte_done & (state_q == ST_WR) & HOST_READY & ~rsv_hit;  // R10 R12
  wire       step      = byte_done & ((state_q == ST_RD) | (state_q == ST_WR));  // R9 R14

  // Read byte selection: master status until the device is ready
  wire [7:0] ptr_byte = (bidx_q == 2'h0) ? map_q[15:8] :
                        (bidx_q == 2'h1) ? map_q[7:0] : 8'h00;
  wire [7:0] rd_byte  = ~HOST_READY ? STATUS_BYTE :  // R12
                        (state_q == ST_PTR_RD) ? ptr_byte : MEM_RD_DATA;  // R13
  wire [7:0] ld_byte  = rd_state ? rd_byte : 8'h00;  // R7

  // Next frame phase from the command byte
  hsmap_state_t cmd_nxt;
  always_comb begin
    cmd_nxt = ST_SKIP;
    if (is_fast) begin
      cmd_nxt = rx_byte[6] ? ST_WR : ST_RD;  // R8
    end else if (rx_byte == `HSMAP_CMD_MEM_RD) begin
      cmd_nxt = ST_RD;  // R14
    end else if (rx_byte == `HSMAP_CMD_MEM_WR) begin
      cmd_nxt = ST_WR;  // R14
    end else if (rx_byte == `HSMAP_CMD_PTR_RD) begin
      cmd_nxt = ST_PTR_RD;  // R13
    end else if (rx_byte == `HSMAP_CMD_PTR_WR) begin
      cmd_nxt = ST_PTR_WR;  // R13
    end
  end

  // ----------------------------------------------------------------
  // Frame sequencer
  // ----------------------------------------------------------------
  // Select high wipes the bit count, so a partial byte never completes
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_q <= ST_CMD;
      bit_q   <= 3'h0;
      bidx_q  <= 2'h0;
    end else if (cs_hi) begin
      state_q <= ST_CMD;  // R4
      bit_q   <= 3'h0;  // R5
      bidx_q  <= 2'h0;
    end else if (rise) begin
      bit_q <= bit_q + 3'h1;  // R2
      if (byte_done && state_q == ST_CMD) begin
        state_q <= cmd_nxt;  // R7 R15
      end else if (byte_done && bidx_q != 2'h3) begin
        bidx_q <= bidx_q + 2'h1;
      end
    end
  end

  // Receive shift; read phases leave it untouched
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rx_q <= 7'h00;
    end else if (rise && !rd_state) begin
      rx_q <= rx_byte[6:0];  // R6
    end
  end

  // ----------------------------------------------------------------
  // Serial output
  // ----------------------------------------------------------------
  // Next byte loads on the falling edge after a boundary, giving the
  // memory half a serial period to answer the new address.
  // Select high empties the shifter, so no bit of an earlier frame
  // leaks into the dummy byte of the next one.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      so_q <= 1'b0;
      tx_q <= 7'h00;
    end else if (cs_hi) begin
      so_q <= 1'b0;  // R4 R7
      tx_q <= 7'h00;  // R4
    end else if (fall && bit_q == 3'h0) begin
      so_q <= ld_byte[7];  // R1
      tx_q <= ld_byte[6:0];
    end else if (fall) begin
      so_q <= tx_q[6];  // R1
      tx_q <= {tx_q[5:0], 1'b0};
    end
  end

  // Drive only inside a frame so other slaves can share the line
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      oe_q <= 1'b0;
    end else begin
      oe_q <= ~cs_hi;  // R18
    end
  end

  // ----------------------------------------------------------------
  // Address pointers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      map_q      <= 16'h0000;
      fast_q     <= 16'h0000;
      use_fast_q <= 1'b0;
    end else if (byte_done && state_q == ST_CMD) begin
      use_fast_q <= is_fast;
      fast_q     <= {`HSMAP_FAST_BASE, rx_byte[5:2]};  // R8
    end else if (byte_done && state_q == ST_PTR_WR && bidx_q == 2'h0) begin
      map_q[15:8] <= rx_byte;  // R13
    end else if (byte_done && state_q == ST_PTR_WR && bidx_q == 2'h1) begin
      map_q[7:0] <= rx_byte;  // R13
    end else if (step && use_fast_q) begin
      fast_q <= nxt_addr;  // R9 R16
    end else if (step) begin
      map_q <= nxt_addr;  // R14 R16
    end
  end

  // Read address is a flop so memory sees a stable value
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rda_q <= 16'h0000;
    end else begin
      rda_q <= cur_addr;  // R11
    end
  end

  // ----------------------------------------------------------------
  // Write path and two-entry buffer
  // ----------------------------------------------------------------
  // A full buffer stalls the held byte; only one byte is held, so a
  // stall longer than one serial byte loses the older write
  wire fill_ready = ~v1_q;
  wire push       = pend_q & fill_ready;
  wire pop        = v0_q & MEM_WR_READY;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      pend_q   <= 1'b0;
      pend_w_q <= 24'h000000;
    end else if (wr_take) begin
      pend_q   <= 1'b1;  // R12
      pend_w_q <= {cur_addr, rx_byte};
    end else if (push) begin
      pend_q <= 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      v0_q <= 1'b0;
      v1_q <= 1'b0;
      b0_q <= 24'h000000;
      b1_q <= 24'h000000;
    end else if (pop && v1_q) begin
      b0_q <= b1_q;
      b1_q <= pend_w_q;
      v1_q <= push;
    end else if (pop || !v0_q) begin
      b0_q <= pend_w_q;
      v0_q <= push;
    end else if (push) begin
      b1_q <= pend_w_q;
      v1_q <= 1'b1;
    end
  end

  assign SO           = so_q;
  assign SO_OE        = oe_q;
  assign MEM_RD_ADDR  = rda_q;
  assign MEM_WR_VALID = v0_q;
  assign MEM_WR_ADDR  = b0_q[23:8];
  assign MEM_WR_DATA  = b0_q[7:0];

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);

  oe_follows_cs_a: assert property (cs_hi |=> !SO_OE)  // R18
    else $error("Serial output driven outside frame");
  so_restart_a: assert property (cs_hi |=> !SO)  // R4
    else $error("Serial output not cleared between frames");
  byte_wrap_a: assert property (byte_done |=> bit_q == 3'h0)  // R2
    else $error("Bit count did not wrap after eight edges");
  cs_restart_a: assert property (cs_hi |=> state_q == ST_CMD && bit_q == 3'h0)  // R4
    else $error("Select high did not restart the frame");
  no_partial_a: assert property ($rose(pend_q) |-> $past(byte_done) && $past(HOST_READY))  // R5
    else $error("Write taken without a complete byte");
  fast_addr_a: assert property (byte_done && state_q == ST_CMD && is_fast
      |=> use_fast_q && fast_q == {`HSMAP_FAST_BASE, $past(rx_byte[5:2])})  // R8
    else $error("Fast command address wrong");
  ptr_load_a: assert property (byte_done && state_q == ST_PTR_WR && bidx_q == 2'h1
      |=> map_q[7:0] == $past(rx_byte))  // R13
    else $error("Pointer low byte not loaded");
  ptr_step_a: assert property (step && !use_fast_q && !at_top
      |=> map_q == $past(map_q) + 16'h0001)  // R14
    else $error("Pointer did not advance");
  ram_stop_a: assert property (step && !use_fast_q && map_q == `HSMAP_RAM_TOP
      |=> map_q == `HSMAP_RAM_TOP)  // R16
    else $error("Pointer ran past the RAM top");
  rsv_block_a: assert property (byte_done && state_q == ST_WR && rsv_hit
      |=> !$rose(pend_q) && $stable(pend_w_q))  // R10
    else $error("Reserved register written");
  wr_block_a: assert property (byte_done && state_q == ST_WR && !HOST_READY
      |=> !$rose(pend_q) && $stable(pend_w_q))  // R12
    else $error("Write taken before ready");
  status_read_a: assert property (fall && bit_q == 3'h0 && rd_state && !HOST_READY
      |=> SO == STATUS_BYTE[7])  // R12
    else $error("Status not returned before ready");
  buf_order_a: assert property (v1_q |-> v0_q)
    else $error("Buffer second entry without first");

  // Serial edge checks: dummy byte, ignored input, fast stepping
  dummy_zero_a: assert property (fall && bit_q == 3'h0 && state_q == ST_CMD |=> !SO)  // R7
    else $error("Dummy byte bit not zero");
  si_ignored_a: assert property (rise && rd_state |=> $stable(rx_q))  // R6
    else $error("Serial input taken during read");
  fast_step_a: assert property (step && use_fast_q && !at_top
      |=> fast_q == $past(fast_q) + 16'h0001)  // R9
    else $error("Fast address did not advance");

  // Main scenarios worth seeing at least once

  read_frame_c: cover property (byte_done && state_q == ST_RD ##[1:300] cs_hi);
  write_drain_c: cover property (v1_q && !MEM_WR_READY ##1 pop);
  ptr_frame_c: cover property (byte_done && state_q == ST_PTR_WR && bidx_q == 2'h1);
  unknown_cmd_c: cover property (byte_done && state_q == ST_CMD && cmd_nxt == ST_SKIP);

endmodule
`default_nettype wire

// ---- sim/hsmap_host_model.sv ----
// Host-side serial master model that frames transfers to the port
`timescale 1ns/1ps
`default_nettype none
module hsmap_host_model #(
  parameter int HALF_NS = 32
) (
  output var logic sck,
  output var logic cs_n,
  output var logic si,
  input  wire logic so
);
  // ----------------------------------------------------------------
  // Idle lines
  // ----------------------------------------------------------------
  initial begin
    sck  = 1'b0;
    cs_n = 1'b1;
    si   = 1'b0;
  end

  // ----------------------------------------------------------------
  // Frame driver
  // ----------------------------------------------------------------
  // One command per frame, select always raised at the end
  task automatic xfer(input bit m3, input logic [31:0] tx, input int nb,
                      output logic [31:0] rx);
    rx = 32'h0;
    // Idle level settles before select, so a mode change makes no edge
    sck = m3;
    #HALF_NS;
    cs_n = 1'b0;
    #HALF_NS;
    for (int i = nb - 1; i >= 0; i--) begin
      sck = 1'b0;
      si = tx[i];
      #HALF_NS;
      rx = {rx[30:0], so};
      sck = 1'b1;
      #HALF_NS;
    end
    // Released data line shows the inverse so a stale bit cannot pass
    si = ~si;
    sck = m3;
    #HALF_NS;
    cs_n = 1'b1;
    #(4 * HALF_NS);
  endtask
endmodule
`default_nettype wire

// ---- sim/hsmap_top_test.sv ----
// Self-checking bench for the host serial memory access port
`timescale 1ns/1ps
`default_nettype none
module hsmap_top_test;
  import hsmap_pkg::*;
  logic             clk;
  logic             rst_n;
  logic             host_ready;
  logic             wr_ready;
  logic [7:0]       status;
  logic [31:0]      rx;
  logic [23:0]      wrq [$];
  int               mismatches;
  int               n_compared;
  wire logic        sck, cs_n, si, so, so_oe, so_line, wr_valid;
  wire logic [15:0] rd_addr, wr_addr;
  wire logic [7:0]  rd_data, wr_data;

  // ----------------------------------------------------------------
  // Clock, far-side line and memory
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Undriven output line shows the inverse so a stale bit never matches
  assign so_line = so_oe ? so : ~so;
  function automatic logic [7:0] mv(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5a;
  endfunction
  assign rd_data = mv(rd_addr);
  // Writes are logged only on a completed handshake
  always @(posedge clk) if (wr_valid === 1'b1 && wr_ready) wrq.push_back({wr_addr, wr_data});

  hsmap_top i_hsmap_top (.CLK(clk), .RST_N(rst_n), .SCK(sck), .CS_N(cs_n), .SI(si),
    .SO(so), .SO_OE(so_oe), .HOST_READY(host_ready), .STATUS_BYTE(status),
    .MEM_RD_ADDR(rd_addr), .MEM_RD_DATA(rd_data), .MEM_WR_VALID(wr_valid),
    .MEM_WR_READY(wr_ready), .MEM_WR_ADDR(wr_addr), .MEM_WR_DATA(wr_data));
  hsmap_host_model i_hsmap_host_model (.sck(sck), .cs_n(cs_n), .si(si), .so(so_line));

  // ----------------------------------------------------------------
  // Compare and closing tasks
  // ----------------------------------------------------------------
  task automatic cmp(input logic [23:0] got, input logic [23:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic cmp_wr(input logic [15:0] a, input logic [7:0] d);
    logic [23:0] e;
    e = 24'hxxxxxx;
    if (wrq.size() > 0) e = wrq.pop_front();
    cmp(e, {a, d}, "write");
  endtask
  task automatic stop_test;
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_ptr;
    i_hsmap_host_model.xfer(1'b0, 32'h8c1234, 24, rx);
    i_hsmap_host_model.xfer(1'b0, 32'h880000, 24, rx);
    cmp(rx[23:0], 24'h001234, "pointer");
    $display("pointer test done");
  endtask
  // Cut byte must neither write nor step the pointer
  task automatic t_part;
    i_hsmap_host_model.xfer(1'b0, 32'h1095, 13, rx);
    cmp({23'h0, so_oe}, 24'h0, "idle enable");
    i_hsmap_host_model.xfer(1'b0, 32'h9477, 16, rx);
    cmp({8'h0, rx[15:0]}, 24'h0, "unknown command");
    i_hsmap_host_model.xfer(1'b0, 32'h880000, 24, rx);
    cmp(rx[23:0], 24'h001234, "after cut");
    cmp(24'(wrq.size()), 24'h0, "cut write");
    $display("partial test done");
  endtask
  // Mode 3 write while the sink stalls, then reads that hit the RAM top
  task automatic t_mem;
    @(negedge clk) wr_ready = 1'b0;
    i_hsmap_host_model.xfer(1'b1, 32'h84a1b2c3, 32, rx);
    cmp(24'(wrq.size()), 24'h0, "stalled");
    cmp({23'h0, wr_valid}, 24'h1, "held");
    @(negedge clk) wr_ready = 1'b1;
    repeat (10) @(negedge clk);
    cmp_wr(16'h1234, 8'ha1);
    cmp_wr(16'h1235, 8'hb2);
    cmp_wr(16'h1236, 8'hc3);
    i_hsmap_host_model.xfer(1'b1, 32'h8c7ffe, 24, rx);
    i_hsmap_host_model.xfer(1'b1, 32'h80a5a5a5, 32, rx);
    cmp(rx[23:0], {mv(16'h7ffe), mv(16'h7fff), mv(16'h7fff)}, "ram top");
    $display("memory test done");
  endtask
  task automatic t_top;
    i_hsmap_host_model.xfer(1'b0, 32'h8cfffe, 24, rx);
    i_hsmap_host_model.xfer(1'b0, 32'h84112233, 32, rx);
    cmp_wr(16'hfffe, 8'h11);
    cmp_wr(16'hffff, 8'h22);
    cmp_wr(16'hffff, 8'h33);
    $display("register top test done");
  endtask
  // Fast access around reserved slots; the pointer stays put
  task automatic t_fast;
    i_hsmap_host_model.xfer(1'b0, 32'h7c99, 16, rx);
    i_hsmap_host_model.xfer(1'b0, 32'h64445566, 32, rx);
    cmp_wr(16'h800f, 8'h99);
    cmp_wr(16'h800a, 8'h55);
    cmp(24'(wrq.size()), 24'h0, "reserved");
    i_hsmap_host_model.xfer(1'b0, 32'h3c0000, 24, rx);
    cmp(rx[23:0], {8'h00, mv(16'h800f), mv(16'h8010)}, "fast read");
    i_hsmap_host_model.xfer(1'b0, 32'h880000, 24, rx);
    cmp(rx[23:0], 24'h00ffff, "map kept");
    $display("fast test done");
  endtask
  task automatic t_nrdy;
    @(negedge clk) host_ready = 1'b0;
    i_hsmap_host_model.xfer(1'b0, 32'h7c77, 16, rx);
    cmp(24'(wrq.size()), 24'h0, "blocked");
    i_hsmap_host_model.xfer(1'b0, 32'h8000, 16, rx);
    cmp(rx[23:0], {16'h0, status}, "status");
    @(negedge clk) host_ready = 1'b1;
    $display("not ready test done");
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    host_ready = 1'b1;
    wr_ready = 1'b1;
    status = 8'h3e;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    t_ptr;
    t_part;
    t_mem;
    t_top;
    t_fast;
    t_nrdy;
    stop_test;
  end
  // Sixteen frames of 1.1 to 2.3 us each, about 27.5 us in all; the limit leaves ample margin
  initial begin
    #200000;
    mismatches++;
    stop_test;
  end
endmodule
`default_nettype wire
